// [rtl/ufb_pkg.sv]
// shared constants, types and helpers of the frame/baud block
package ufb_pkg;
    localparam int           ADDR_W     = 8;
    localparam logic [7:0]   OFF_FFC    = 8'h00;
    localparam logic [7:0]   OFF_BDH    = 8'h04;
    localparam logic [7:0]   OFF_BDL    = 8'h08;
    localparam logic [7:0]   OFF_CTL    = 8'h0c;
    localparam logic [7:0]   OFF_STS    = 8'h10;
    localparam logic [7:0]   OFF_MSK    = 8'h14;
    localparam logic [7:0]   OFF_TXD    = 8'h18;
    localparam logic [7:0]   OFF_RXD    = 8'h1c;
    localparam logic [7:0]   FFC_RST    = 8'h06;
    localparam logic [3:0]   BDH_RST    = 4'h0;
    localparam logic [7:0]   BDL_RST    = 8'h00;
    localparam logic [3:0]   CTL_RST    = 4'h0;
    localparam int           CTL_TXEN   = 0;
    localparam int           CTL_RXEN   = 1;
    localparam int           CTL_DS     = 2;
    localparam int           CTL_CSZ2   = 3;
    localparam int           ST_RXDONE  = 0;
    localparam int           ST_TXDONE  = 1;
    localparam int           ST_PERR    = 2;
    localparam logic [3:0]   OS_NORM    = 4'hf;
    localparam logic [3:0]   OS_DBL     = 4'h7;
    localparam logic [3:0]   HALF_NORM  = 4'h7;
    localparam logic [3:0]   HALF_DBL   = 4'h3;
    localparam logic [1:0]   MODE_SYNC  = 2'h1;
    localparam logic [1:0]   RESP_OKAY  = 2'h0;
    localparam logic [1:0]   RESP_SLVE  = 2'h2;

    typedef enum logic [1:0] {
        PM_OFF  = 2'b00,
        PM_RSV  = 2'b01,
        PM_EVEN = 2'b10,
        PM_ODD  = 2'b11
    } ufb_pm_e;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_BITS  = 2'b10
    } ufb_rx_e;

    typedef struct packed {
        logic [1:0] mode;
        ufb_pm_e    pm;
        logic       sbs;
        logic [1:0] csz;
        logic       pol;
    } ufb_fmt_s;

    typedef struct packed {
        logic [11:0] div;
        logic        ds;
        logic        reload;
    } ufb_baud_cfg_s;

    function automatic logic [3:0] ufb_len(input logic [2:0] c);
        case (c)
            3'b000:  return 4'h5;
            3'b001:  return 4'h6;
            3'b010:  return 4'h7;
            3'b111:  return 4'h9;
            default: return 4'h8;
        endcase
    endfunction : ufb_len

    function automatic logic [8:0] ufb_mask(input logic [3:0] len);
        return 9'h1ff >> (4'h9 - len);
    endfunction : ufb_mask

    function automatic logic ufb_par(input logic [8:0] d,
                                     input logic odd);
        return (^d) ^ odd;
    endfunction : ufb_par
endpackage : ufb_pkg

// [rtl/ufb_baud.sv]
// baud prescaler with oversampling stage
`timescale 1ns/1ps
`default_nettype none
module ufb_baud (
    input  wire logic                   mclk,
    input  wire logic                   rst,
    input  wire ufb_pkg::ufb_baud_cfg_s cfg,
    output logic                        os_tick,
    output logic                        bit_tick
);
    import ufb_pkg::*;

    typedef struct packed {
        logic [11:0] pc;
        logic [3:0]  osc;
        logic        os_tick;
        logic        bit_tick;
    } ufb_bd_s;

    ufb_bd_s    s_ff;
    ufb_bd_s    nxt_s;
    logic [3:0] lim;

    assign lim      = cfg.ds ? OS_DBL : OS_NORM;
    assign os_tick  = s_ff.os_tick;
    assign bit_tick = s_ff.bit_tick;

    always_comb begin
        nxt_s          = s_ff;
        nxt_s.os_tick  = 1'b0;
        nxt_s.bit_tick = 1'b0;
        if (cfg.reload) begin
            nxt_s.pc  = cfg.div;
            nxt_s.osc = 4'h0;
        end else if (s_ff.pc == 12'h000) begin
            nxt_s.pc      = cfg.div;
            nxt_s.os_tick = 1'b1;
            if (s_ff.osc == lim) begin
                nxt_s.osc      = 4'h0;
                nxt_s.bit_tick = 1'b1;
            end else begin
                nxt_s.osc = s_ff.osc + 4'h1;
            end
        end else begin
            nxt_s.pc = s_ff.pc - 12'h001;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    AST_RELOAD_NOW: assert property (
        cfg.reload |=> (s_ff.pc == $past(cfg.div)) && !os_tick)
        else $error("prescaler not reloaded on low byte write");
    AST_TICK_GAP: assert property (
        (os_tick && cfg.div == 12'h001 && !cfg.reload) ##1 !cfg.reload
        |-> !os_tick ##1 os_tick)
        else $error("tick spacing is not divisor plus one");
    AST_OS_RATIO: assert property (
        bit_tick |-> $past(s_ff.osc) == $past(lim) && os_tick)
        else $error("bit tick at wrong oversample count");
    COV_DBL: cover property (bit_tick && cfg.ds);
endmodule : ufb_baud
`default_nettype wire

// [rtl/ufb_top.sv]
// usart frame format and baud configuration with axi4-lite slave
`timescale 1ns/1ps
`default_nettype none
module ufb_top (
    input  wire logic                      mclk,
    input  wire logic                      rst,
    input  wire logic [ufb_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [ufb_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    input  wire logic                      serial_rx_line,
    input  wire logic                      sync_serial_clock,
    output logic                           serial_tx_line,
    output logic                           irq
);
    import ufb_pkg::*;

    typedef struct packed {
        logic        aw_hold;
        logic [7:0]  aw_addr;
        logic        w_hold;
        logic [31:0] w_data;
        logic        w_be0;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic [7:0]  ffc;
        logic [3:0]  bdh;
        logic [7:0]  bdl;
        logic [3:0]  ctl;
        logic [2:0]  sts;
        logic [2:0]  msk;
        logic [8:0]  txd;
        logic        txgo;
        logic        reload;
        logic        irq;
        logic        rx1;
        logic        rx2;
        logic        xk1;
        logic        xk2;
        logic        xk3;
        logic        tx_busy;
        logic [12:0] tx_sh;
        logic [3:0]  tx_cnt;
        logic        tx_line;
        ufb_rx_e     rx_st;
        logic [3:0]  rx_os;
        logic [3:0]  rx_idx;
        logic [10:0] rx_sh;
        logic [8:0]  rxd;
    } ufb_st_s;

    ufb_st_s       s_ff;
    ufb_st_s       nxt_s;
    ufb_fmt_s      fmt;
    ufb_baud_cfg_s bcfg;
    logic          os_tick;
    logic          bit_tick;
    logic          sync_md;
    logic          pen;
    logic          odd;
    logic [3:0]    len;
    logic [3:0]    flen;
    logic          tx_edge;
    logic          rx_edge;
    logic          tx_step;
    logic          do_wr;
    logic          rx_fin;

    ////////////////////////////////////////////////////////////////////
    assign fmt     = ufb_fmt_s'(s_ff.ffc);
    assign sync_md = (fmt.mode == MODE_SYNC);
    assign pen     = fmt.pm[1];
    assign odd     = (fmt.pm == PM_ODD);
    assign len     = ufb_len({s_ff.ctl[CTL_CSZ2], fmt.csz});
    assign flen    = 4'h2 + len + {3'h0, pen} + {3'h0, fmt.sbs};
    // polarity 0 shifts out on rise, samples on fall
    assign tx_edge = fmt.pol ? (s_ff.xk3 & ~s_ff.xk2)
                             : (s_ff.xk2 & ~s_ff.xk3);
    assign rx_edge = fmt.pol ? (s_ff.xk2 & ~s_ff.xk3)
                             : (s_ff.xk3 & ~s_ff.xk2);
    assign tx_step = sync_md ? tx_edge : bit_tick;
    assign do_wr   = s_ff.aw_hold && s_ff.w_hold && !s_ff.bvalid;
    assign rx_fin  = (s_ff.rx_st == RX_BITS) && s_ff.rx_idx == len + {3'h0, pen}
                     && (sync_md ? rx_edge
                                 : (os_tick && s_ff.rx_os == (bcfg.ds ? OS_DBL
                                                                   : OS_NORM)));
    assign bcfg.div    = {s_ff.bdh, s_ff.bdl};
    assign bcfg.ds     = s_ff.ctl[CTL_DS] && !sync_md;
    assign bcfg.reload = s_ff.reload;

    assign s_axi_awready  = s_ff.awready;
    assign s_axi_wready   = s_ff.wready;
    assign s_axi_bresp    = s_ff.bresp;
    assign s_axi_bvalid   = s_ff.bvalid;
    assign s_axi_arready  = s_ff.arready;
    assign s_axi_rdata    = s_ff.rdata;
    assign s_axi_rresp    = s_ff.rresp;
    assign s_axi_rvalid   = s_ff.rvalid;
    assign serial_tx_line = s_ff.tx_line;
    assign irq            = s_ff.irq;

    ufb_baud u_baud (
        .mclk     (mclk),
        .rst      (rst),
        .cfg      (bcfg),
        .os_tick  (os_tick),
        .bit_tick (bit_tick)
    );

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [31:0] rd;
        logic [1:0]  rr;
        logic [2:0]  set;
        logic [2:0]  clr;
        logic        samp;
        logic [3:0]  lim;
        logic [8:0]  dat;
        rd    = 32'h0;
        rr    = RESP_OKAY;
        set   = 3'h0;
        clr   = 3'h0;
        samp  = 1'b0;
        lim   = bcfg.ds ? OS_DBL : OS_NORM;
        dat   = s_ff.rx_sh[8:0] & ufb_mask(len);
        nxt_s = s_ff;
        nxt_s.reload = 1'b0;
        // pins pass two flops before use
        nxt_s.rx1 = serial_rx_line;
        nxt_s.rx2 = s_ff.rx1;
        nxt_s.xk1 = sync_serial_clock;
        nxt_s.xk2 = s_ff.xk1;
        nxt_s.xk3 = s_ff.xk2;

        if (s_ff.awready && s_axi_awvalid) begin
            nxt_s.aw_hold = 1'b1;
            nxt_s.aw_addr = s_axi_awaddr;
        end
        if (s_ff.wready && s_axi_wvalid) begin
            nxt_s.w_hold = 1'b1;
            nxt_s.w_data = s_axi_wdata;
            nxt_s.w_be0  = s_axi_wstrb[0];
        end
        if (s_ff.bvalid && s_axi_bready) begin
            nxt_s.bvalid = 1'b0;
        end
        if (do_wr) begin
            nxt_s.aw_hold = 1'b0;
            nxt_s.w_hold  = 1'b0;
            nxt_s.bvalid  = 1'b1;
            nxt_s.bresp   = RESP_OKAY;
            if (s_ff.aw_addr == OFF_FFC) begin
                if (s_ff.w_be0) nxt_s.ffc = s_ff.w_data[7:0];
            end else if (s_ff.aw_addr == OFF_BDH) begin
                if (s_ff.w_be0) nxt_s.bdh = s_ff.w_data[3:0];
            end else if (s_ff.aw_addr == OFF_BDL) begin
                if (s_ff.w_be0) begin
                    nxt_s.bdl    = s_ff.w_data[7:0];
                    nxt_s.reload = 1'b1;
                end
            end else if (s_ff.aw_addr == OFF_CTL) begin
                if (s_ff.w_be0) nxt_s.ctl = s_ff.w_data[3:0];
            end else if (s_ff.aw_addr == OFF_STS) begin
                if (s_ff.w_be0) clr = s_ff.w_data[2:0];
            end else if (s_ff.aw_addr == OFF_MSK) begin
                if (s_ff.w_be0) nxt_s.msk = s_ff.w_data[2:0];
            end else if (s_ff.aw_addr == OFF_TXD) begin
                // ignored while a frame is still queued or sent
                if (s_ff.ctl[CTL_TXEN] && !s_ff.tx_busy && !s_ff.txgo) begin
                    nxt_s.txd  = s_ff.w_data[8:0];
                    nxt_s.txgo = 1'b1;
                end
            end else if (s_ff.aw_addr != OFF_RXD) begin
                nxt_s.bresp = RESP_SLVE;
            end
        end
        nxt_s.awready = !nxt_s.aw_hold && !nxt_s.bvalid;
        nxt_s.wready  = !nxt_s.w_hold && !nxt_s.bvalid;

        if (s_axi_araddr == OFF_FFC) begin
            rd[7:0] = s_ff.ffc;
        end else if (s_axi_araddr == OFF_BDH) begin
            rd[3:0] = s_ff.bdh;
        end else if (s_axi_araddr == OFF_BDL) begin
            rd[7:0] = s_ff.bdl;
        end else if (s_axi_araddr == OFF_CTL) begin
            rd[4:0] = {s_ff.tx_busy, s_ff.ctl};
        end else if (s_axi_araddr == OFF_STS) begin
            rd[2:0] = s_ff.sts;
        end else if (s_axi_araddr == OFF_MSK) begin
            rd[2:0] = s_ff.msk;
        end else if (s_axi_araddr == OFF_TXD) begin
            rd[8:0] = s_ff.txd;
        end else if (s_axi_araddr == OFF_RXD) begin
            rd[8:0] = s_ff.rxd;
        end else begin
            rr = RESP_SLVE;
        end
        if (s_ff.rvalid && s_axi_rready) begin
            nxt_s.rvalid = 1'b0;
        end
        if (s_ff.arready && s_axi_arvalid) begin
            nxt_s.rvalid = 1'b1;
            nxt_s.rdata  = rd;
            nxt_s.rresp  = rr;
        end
        nxt_s.arready = !nxt_s.rvalid;

        // transmitter: frame is built whole, then shifted lsb first
        if (s_ff.txgo && !s_ff.tx_busy) begin
            nxt_s.txgo    = 1'b0;
            nxt_s.tx_busy = 1'b1;
            nxt_s.tx_cnt  = flen;
            nxt_s.tx_sh   = 13'h1ffe;
            for (int i = 0; i < 9; i++) begin
                if (i < int'(len)) nxt_s.tx_sh[i+1] = s_ff.txd[i];
            end
            if (pen) begin
                nxt_s.tx_sh[len+1] =
                    ufb_par(s_ff.txd & ufb_mask(len), odd);
            end
        end else if (s_ff.tx_busy && tx_step) begin
            if (s_ff.tx_cnt == 4'h0) begin
                nxt_s.tx_busy = 1'b0;
                set[ST_TXDONE] = 1'b1;
            end else begin
                nxt_s.tx_line = s_ff.tx_sh[0];
                nxt_s.tx_sh   = {1'b1, s_ff.tx_sh[12:1]};
                nxt_s.tx_cnt  = s_ff.tx_cnt - 4'h1;
            end
        end

        // receiver: async samples mid-bit on oversample ticks
        case (s_ff.rx_st)
            RX_IDLE: begin
                nxt_s.rx_os  = 4'h0;
                nxt_s.rx_idx = 4'h0;
                if (s_ff.ctl[CTL_RXEN] && !s_ff.rx2) begin
                    if (sync_md && rx_edge) begin
                        nxt_s.rx_st = RX_BITS;
                    end else if (!sync_md && os_tick) begin
                        nxt_s.rx_st = RX_START;
                    end
                end
            end
            RX_START: begin
                if (os_tick) begin
                    nxt_s.rx_os = s_ff.rx_os + 4'h1;
                    if (s_ff.rx_os == (bcfg.ds ? HALF_DBL : HALF_NORM)) begin
                        nxt_s.rx_os = 4'h0;
                        nxt_s.rx_st = s_ff.rx2 ? RX_IDLE : RX_BITS;
                    end
                end
            end
            RX_BITS: begin
                if (sync_md) begin
                    samp = rx_edge;
                end else if (os_tick) begin
                    samp = (s_ff.rx_os == lim);
                    nxt_s.rx_os = samp ? 4'h0 : s_ff.rx_os + 4'h1;
                end
                if (samp) begin
                    nxt_s.rx_sh[s_ff.rx_idx] = s_ff.rx2;
                    nxt_s.rx_idx = s_ff.rx_idx + 4'h1;
                    // only the first stop is looked at
                    if (rx_fin) begin
                        nxt_s.rx_st = RX_IDLE;
                        nxt_s.rxd   = dat;
                        set[ST_RXDONE] = 1'b1;
                        set[ST_PERR] = pen && (ufb_par(dat, odd)
                                       != s_ff.rx_sh[len]);
                    end
                end
            end
            default: begin
                nxt_s.rx_st = RX_IDLE;
            end
        endcase
        if (!s_ff.ctl[CTL_RXEN]) begin
            nxt_s.rx_st = RX_IDLE;
        end

        // set beats clear when both land together
        nxt_s.sts = (s_ff.sts & ~clr) | set;
        nxt_s.irq = |(nxt_s.sts & nxt_s.msk);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_ff         <= '0;
            s_ff.ffc     <= FFC_RST;
            s_ff.bdh     <= BDH_RST;
            s_ff.bdl     <= BDL_RST;
            s_ff.ctl     <= CTL_RST;
            s_ff.tx_line <= 1'b1;
            s_ff.tx_sh   <= '1;
            s_ff.rx_st   <= RX_IDLE;
        end else begin
            s_ff <= nxt_s;
        end
    end

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    AST_TX_IDLE_HIGH: assert property (
        !s_ff.tx_busy |-> serial_tx_line)
        else $error("tx line low outside a frame");
    AST_TX_LEN: assert property (
        (s_ff.txgo && !s_ff.tx_busy) |=> s_ff.tx_busy &&
        s_ff.tx_cnt == 4'h2 + $past(len) + {3'h0, $past(pen)}
                       + {3'h0, $past(fmt.sbs)})
        else $error("frame length does not match format");
    AST_PERR_ONLY_EN: assert property (
        $rose(s_ff.sts[ST_PERR]) |-> $past(fmt.pm[1]))
        else $error("parity error with parity disabled");
    AST_RX_UPPER_ZERO: assert property (
        rx_fin |=> (s_ff.rxd & ~ufb_mask($past(len))) == 9'h000)
        else $error("unused received bits not zero");
    AST_BDH_RSV: assert property (
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_BDH)
        |=> s_axi_rvalid && s_axi_rdata[31:4] == 28'h0)
        else $error("reserved divisor bits read nonzero");
    AST_WR_RELOAD: assert property (
        (do_wr && s_ff.aw_addr == OFF_BDL && s_ff.w_be0)
        |=> s_ff.reload && bcfg.div[7:0] == $past(s_ff.w_data[7:0]))
        else $error("low byte write did not reload");
    AST_SYNC_EDGE: assert property (
        (sync_md && $changed(serial_tx_line)) |-> $past(tx_edge))
        else $error("sync tx changed off its edge");
    AST_IRQ_LEVEL: assert property (
        (s_ff.sts & s_ff.msk) != 3'h0 |-> irq ##1 1'b1)
        else $error("unmasked status without interrupt");
    AST_BRESP: assert property (
        do_wr |=> s_axi_bvalid [*1] ##1 1'b1)
        else $error("write not answered");

    COV_TX: cover property (s_ff.tx_busy && tx_step && s_ff.tx_cnt == 4'h0);
    COV_RX: cover property (rx_fin && pen);
    COV_PERR: cover property ($rose(s_ff.sts[ST_PERR]));
    COV_SYNC: cover property (sync_md && rx_fin);
endmodule : ufb_top
`default_nettype wire

// [testbench/ufb_remote.sv]
// behavioural remote serial transceiver
`timescale 1ns/1ps
`default_nettype none
module ufb_remote (
    input  wire logic mclk,
    input  wire logic line_in,
    input  wire logic done,
    output logic      line_out,
    output logic      sclk_out
);
    initial line_out = 1'b1;
    initial sclk_out = 1'b0;
    ////////////////////////////////////////////////////////////////////////
    task automatic put(input logic v, input int b);
        line_out <= v;
        repeat (b) @(posedge mclk);
    endtask : put
    // one stop only: receiver must not depend on stop select
    task automatic send(input logic [8:0] d, input int n, p,
                        input logic par, input int b);
        @(posedge mclk);
        put(1'b0, b);
        for (int i = 0; i < n; i++) put(d[i], b);
        if (p != 0) put(par, b);
        put(1'b1, b);
    endtask : send
    // mid-bit sampling, so a wrong bit period shows as bad data
    task automatic catch(input int n, p, b, output logic [8:0] d,
                         output logic par, output int len);
        d = '0;
        par = 1'b0;
        len = 0;
        while (line_in !== 1'b0 && len < 9000) begin
            @(posedge mclk);
            len++;
        end
        len = b / 2 + (n + p) * b;
        repeat (b / 2) @(posedge mclk);
        for (int i = 0; i < n; i++) begin
            repeat (b) @(posedge mclk);
            d[i] = line_in;
        end
        if (p != 0) begin
            repeat (b) @(posedge mclk);
            par = line_in;
        end
        while (done !== 1'b1 && len < 40 * b) begin
            @(posedge mclk);
            len++;
        end
    endtask : catch
    // clock master for slave-clocked frames, full duplex; idles at pol
    task automatic sync_xfer(input logic pol, input logic [10:0] t,
                             output logic [10:0] r);
        sclk_out <= pol;
        repeat (8) @(posedge mclk);
        for (int i = 0; i < 11; i++) begin
            sclk_out <= ~pol;
            line_out <= t[i];
            repeat (8) @(posedge mclk);
            sclk_out <= pol;
            r[i] = line_in;
            repeat (8) @(posedge mclk);
        end
    endtask : sync_xfer
endmodule : ufb_remote
`default_nettype wire

// [testbench/testbench.sv]
// self-checking bench of the frame and baud block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import ufb_pkg::*;
    logic              mclk = 1'b0;
    logic              rst = 1'b1;
    logic [ADDR_W-1:0] awaddr = '0;
    logic [ADDR_W-1:0] araddr = '0;
    logic [31:0]       wdata = '0;
    logic              awvalid = 1'b0;
    logic              wvalid = 1'b0;
    logic              bready = 1'b0;
    logic              arvalid = 1'b0;
    logic              rready = 1'b0;
    logic              awready, wready, bvalid, arready, rvalid;
    logic              txl, rxl, irq, sclk;
    logic [1:0]        bresp, rresp;
    logic [31:0]       rdata;
    int                n_fail = 0;
    int                samples_checked = 0;
    int                cyc = 0;
    always #2.5 mclk = ~mclk;
    ufb_top dut (.mclk(mclk), .rst(rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .serial_rx_line(rxl),
        .sync_serial_clock(sclk), .serial_tx_line(txl), .irq(irq));
    ufb_remote rem (.mclk(mclk), .line_in(txl), .done(irq),
                    .line_out(rxl), .sclk_out(sclk));
    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            n_fail++;
            end_of_test();
        end
    end
    task automatic check(input logic [31:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        r = bresp;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        d = rdata;
        r = rresp;
    endtask : rd
    function automatic int elen(input logic [2:0] c);
        return (c == 3'h7) ? 9 : (c > 3'h3) ? 8 : 5 + c;
    endfunction : elen
    // sets divisor, double speed, size, parity, stop; returns bit time
    task automatic cfg(input logic [2:0] c, input logic [1:0] pm,
                       input logic s, ds, input logic [7:0] dv,
                       output int b);
        logic [1:0] r;
        wr(OFF_BDH, 32'h0, r);
        wr(OFF_BDL, {24'h0, dv}, r);
        wr(OFF_CTL, {28'h0, c[2], ds, 2'h3}, r);
        wr(OFF_FFC, {24'h0, 2'h0, pm, s, c[1:0], 1'b0}, r);
        b = (ds ? 8 : 16) * (dv + 1);
    endtask : cfg
    initial begin
        logic [31:0] v, m, d;
        logic [1:0]  r, pm;
        logic [2:0]  c;
        logic [8:0]  gd;
        logic [10:0] gx;
        logic        gp, ep, bad, sb;
        int          b, gl, n, p, ln;
        static logic [2:0] sz [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h4};
        void'($urandom(32'hd6dfb2aa));
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        rd(OFF_FFC, v, r);
        check(v, 32'h06);
        rd(OFF_BDL, v, r);
        check(v, 32'h0);
        rd(8'h20, v, r);
        check(r, RESP_SLVE);
        wr(8'h24, 32'h1, r);
        check(r, RESP_SLVE);
        wr(OFF_BDH, 32'hff, r);
        rd(OFF_BDH, v, r);
        check(v, 32'h0f);
        wr(OFF_MSK, 32'h7, r);
        // divisor only changed between frames
        for (int i = 0; i < 20; i++) begin
            c = sz[i % 6];
            pm = i % 4;
            n = elen(c);
            p = pm[1];
            m = (32'h1 << n) - 1;
            sb = $urandom % 2;
            cfg(c, pm, sb, i > 13, (i / 6) % 3, b);
            d = $urandom;
            ep = ^(d & m) ^ pm[0];
            fork
                rem.catch(n, p, b, gd, gp, gl);
                wr(OFF_TXD, d, r);
            join
            check(gd, d & m);
            if (p != 0) check(gp, ep);
            rd(OFF_FFC, v, r);
            check(v, {24'h0, 2'h0, pm, sb, c[1:0], 1'b0});
            ln = (2 + n + p + sb) * b;
            check(gl >= ln - b / 2 && gl <= ln + b / 2, 1'b1);
            wr(OFF_STS, 32'h7, r);
            bad = $urandom % 2;
            wr(OFF_MSK, {29'h0, {3{bad}}}, r);
            rem.send(d, n, p, ep ^ bad, b);
            repeat (b) @(posedge mclk);
            check(irq, bad);
            rd(OFF_STS, v, r);
            check(v[2:0], {p[0] & bad, 2'b01});
            rd(OFF_RXD, v, r);
            check(v, d & m);
            wr(OFF_STS, 32'h7, r);
            wr(OFF_MSK, 32'h7, r);
            check(irq, 1'b0);
        end
        // slave-clocked 8-bit frames, both polarities, both ways at once
        for (int k = 0; k < 2; k++) begin
            d = $urandom;
            v = $urandom;
            wr(OFF_FFC, {24'h0, 2'h1, 5'h03, k[0]}, r);
            wr(OFF_TXD, d, r);
            rem.sync_xfer(k[0], {2'h3, v[7:0], 1'b0}, gx);
            check(gx, {2'h3, d[7:0], 1'b0});
            rd(OFF_RXD, m, r);
            check(m, v & 32'hff);
            rd(OFF_STS, m, r);
            check(m, 32'h3);
            wr(OFF_STS, 32'h7, r);
        end
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
